/* verilog/dsca_pkg.sv */
package dsca_pkg;
   // Scan chain numbers as presented by the test access port.
   localparam logic [3:0] CHAIN_ITAG = 4'h4;
   localparam logic [3:0] CHAIN_DTAG = 4'h5;
   localparam logic [3:0] CHAIN_CP = 4'hF;
   // Coprocessor access chain layout.
   localparam int CP_LEN = 39;
   localparam int DIR_BIT = 38;
   localparam int ADDR_HI = 37;
   localparam int ADDR_LO = 32;
   localparam int VAL_HI = 31;
   localparam int REGION_BIT = 5;
   localparam int SIDE_BIT = 0;
   localparam logic [5:0] FLUSH_ADDR = 6'h0F;
   localparam int FLUSH_STATUS_BIT = 31;
   // Tag chain layout, addressing and reading formats.
   localparam int TAG_LEN = 29;
   localparam int IDX_HI = 28;
   localparam int IDX_LO = 22;
   localparam int SEG_HI = 5;
   localparam int VALID_BIT = 28;
   localparam int DIRTY_BIT = 27;
   localparam int TAG_W = 27;
   // Reset values.
   localparam logic [CP_LEN-1:0] CHAIN_RESET = 39'h00_0000_0000;
   localparam logic [31:0] RESULT_RESET = 32'h0000_0000;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_READ = 2'b01,
      ST_DONE = 2'b10
   } dsca_state_type;
endpackage : dsca_pkg

/* verilog/dsca_xfer_if.sv */
interface dsca_xfer_if;
   logic req_tgl;
   logic [38:0] cmd;
   logic [3:0] chain;
   logic ack_tgl;
   logic [31:0] result;

   modport scan (output req_tgl, output cmd, output chain, input ack_tgl, input result);
   modport core (input req_tgl, input cmd, input chain, output ack_tgl, output result);
endinterface : dsca_xfer_if

/* verilog/dsca_core_engine.sv */
module dsca_core_engine (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst,
   // Request channel from the scan side.
   dsca_xfer_if.core xfer,
   // Processor state.
   input wire logic debug_state,
   // Coprocessor register port.
   output logic cp_wr_reg,
   output logic cp_rd_reg,
   output logic cp_region_reg,
   output logic [3:0] cp_num_reg,
   output logic cp_iside_reg,
   output logic [31:0] cp_wdata_reg,
   input wire logic [31:0] cp_rdata,
   // Instruction cache flush.
   output logic instruction_cache_flush_reg,
   input wire logic instruction_cache_flush_done,
   // Tag array port.
   output logic tag_rd_reg,
   output logic tag_data_cache_reg,
   output logic [6:0] tag_index_reg,
   output logic [5:0] tag_segment_reg,
   input wire logic tag_valid,
   input wire logic tag_dirty,
   input wire logic [26:0] tag_value
);
   import dsca_pkg::*;

   logic req_meta_reg;
   logic req_sync_reg;
   logic req_seen_reg;
   logic ack_reg;
   logic flush_busy_reg;
   logic rd_cp_reg;
   logic rd_tag_reg;
   logic [31:0] result_reg;
   dsca_state_type state_reg;
   logic new_req;
   logic is_cp;
   logic is_tag;
   logic is_write;
   logic is_flush;
   logic [5:0] addr;

   assign xfer.ack_tgl = ack_reg;
   assign xfer.result = result_reg;
   assign addr = xfer.cmd[ADDR_HI:ADDR_LO];
   assign is_cp = (xfer.chain == CHAIN_CP);
   assign is_tag = (xfer.chain == CHAIN_ITAG) || (xfer.chain == CHAIN_DTAG);
   assign is_write = xfer.cmd[DIR_BIT];
   assign is_flush = is_cp && (addr == FLUSH_ADDR);
   assign new_req = (req_sync_reg != req_seen_reg) && (state_reg == ST_IDLE);

   // Only the mapped addresses reach the register port; others read as zero.
   function automatic logic addr_mapped(input logic [5:0] a);
      logic [3:0] n;
      n = a[4:1];
      if (a[REGION_BIT]) begin
         addr_mapped = 1'b1;
      end else if (n == 4'h2 || n == 4'h5 || n == 4'h9) begin
         addr_mapped = 1'b1;
      end else if (n == 4'h0 || n == 4'h1 || n == 4'h3 || n == 4'hF) begin
         addr_mapped = !a[SIDE_BIT];
      end else begin
         addr_mapped = 1'b0;
      end
   endfunction : addr_mapped

   // The command word is stable while a toggle is outstanding, so only the toggle is synchronised.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         req_meta_reg <= 1'b0;
         req_sync_reg <= 1'b0;
      end else begin
         req_meta_reg <= xfer.req_tgl;
         req_sync_reg <= req_meta_reg;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_reg <= ST_IDLE;
         req_seen_reg <= 1'b0;
         ack_reg <= 1'b0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (new_req) begin
                  if (debug_state && !is_write && ((is_cp && !is_flush) || is_tag)) begin
                     state_reg <= ST_READ;
                  end else begin
                     state_reg <= ST_DONE;
                  end
               end
            end
            ST_READ: begin
               state_reg <= ST_DONE;
            end
            default: begin
               req_seen_reg <= req_sync_reg;
               ack_reg <= !ack_reg;
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // Strobes last one cycle; outside debug state nothing is issued.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cp_wr_reg <= 1'b0;
         cp_rd_reg <= 1'b0;
         instruction_cache_flush_reg <= 1'b0;
         tag_rd_reg <= 1'b0;
      end else begin
         cp_wr_reg <= new_req && debug_state && is_cp && !is_flush && is_write
            && addr_mapped(addr);
         cp_rd_reg <= new_req && debug_state && is_cp && !is_flush && !is_write
            && addr_mapped(addr);
         instruction_cache_flush_reg <= new_req && debug_state && is_flush && is_write;
         tag_rd_reg <= new_req && debug_state && is_tag;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cp_region_reg <= 1'b0;
         cp_num_reg <= 4'h0;
         cp_iside_reg <= 1'b0;
         cp_wdata_reg <= RESULT_RESET;
         tag_data_cache_reg <= 1'b0;
         tag_index_reg <= 7'h00;
         tag_segment_reg <= 6'h00;
      end else if (new_req) begin
         cp_region_reg <= addr[REGION_BIT];
         cp_num_reg <= addr[4:1];
         cp_iside_reg <= addr[SIDE_BIT];
         cp_wdata_reg <= xfer.cmd[VAL_HI:0];
         tag_data_cache_reg <= (xfer.chain == CHAIN_DTAG);
         tag_index_reg <= xfer.cmd[IDX_HI:IDX_LO];
         tag_segment_reg <= xfer.cmd[SEG_HI:0];
      end
   end

   // Port read data arrives one cycle after the strobe, so the read kind is kept a cycle longer.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rd_cp_reg <= 1'b0;
         rd_tag_reg <= 1'b0;
      end else begin
         rd_cp_reg <= cp_rd_reg;
         rd_tag_reg <= tag_rd_reg;
      end
   end

   // A new flush request wins over a completion in the same cycle.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         flush_busy_reg <= 1'b0;
      end else if (instruction_cache_flush_reg) begin
         flush_busy_reg <= 1'b1;
      end else if (instruction_cache_flush_done) begin
         flush_busy_reg <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         result_reg <= RESULT_RESET;
      end else if (new_req) begin
         if (debug_state && is_flush && !is_write) begin
            result_reg <= {flush_busy_reg, 31'h0000_0000};
         end else begin
            result_reg <= RESULT_RESET;
         end
      end else if (state_reg == ST_DONE) begin
         if (rd_tag_reg) begin
            // Instruction cache lines are never dirty.
            result_reg <= {3'h0, tag_valid, tag_dirty && tag_data_cache_reg, tag_value};
         end else if (rd_cp_reg) begin
            result_reg <= cp_rdata;
         end
      end
   end

   sequence req_taken;
      new_req;
   endsequence

   sequence ack_flip;
      ack_reg != $past(ack_reg);
   endsequence

   ack_bound_a: assert property (@(posedge sys_clk) disable iff (rst)
      req_taken |-> ##[2:3] ack_flip) else $error("request not answered in time");
   flush_strobe_a: assert property (@(posedge sys_clk) disable iff (rst)
      new_req && debug_state && is_flush && is_write |=> instruction_cache_flush_reg ##1 flush_busy_reg)
      else $error("flush write did not start a flush");
   flush_status_a: assert property (@(posedge sys_clk) disable iff (rst)
      new_req && debug_state && is_flush && !is_write |=>
      result_reg[FLUSH_STATUS_BIT] == $past(flush_busy_reg))
      else $error("flush status bit wrong");
   nondebug_quiet_a: assert property (@(posedge sys_clk) disable iff (rst)
      new_req && !debug_state |=> !cp_wr_reg && !cp_rd_reg && !instruction_cache_flush_reg && !tag_rd_reg
      ##1 result_reg == RESULT_RESET) else $error("access acted outside debug state");
   instruction_cache_dirty_a: assert property (@(posedge sys_clk) disable iff (rst)
      state_reg == ST_DONE && rd_tag_reg && !tag_data_cache_reg |=> result_reg[DIRTY_BIT] == 1'b0)
      else $error("instruction tag read shows dirty");
   bad_addr_a: assert property (@(posedge sys_clk) disable iff (rst)
      new_req && is_cp && !addr[REGION_BIT] && addr[4:1] == 4'h0 && addr[SIDE_BIT]
      |=> !cp_wr_reg && !cp_rd_reg) else $error("unmapped register accessed");
endmodule : dsca_core_engine

/* verilog/dsca_scan_top.sv */
// Contract
// - A 39-bit chain reads or writes any coprocessor register in debug state.
// - Bit 38 is direction, bits 37:32 address, bits 31:0 value.
// - Address bit 37 clear: bits 36:33 register, bit 32 picks instruction side.
// - Address bit 37 set: protection region, bits 36:33 region, bit 32 side.
// - Writing pseudo address 0 0111 1 flushes the instruction cache in debug state.
// - Reading that address returns bit 31 set while the flush is still running.
// - Chain 4 reads instruction tags, chain 5 data tags, in one shared format.
// - After update the chain holds valid 28, dirty 27, tag 26:0.
// - Instruction tag reads always show dirty as zero.
// - Uncached system-speed accesses reach external memory, not the cache.
module dsca_scan_top (
   // Core clock domain.
   input wire logic sys_clk,
   input wire logic rst,
   // Test clock domain, fed by the test access port controller.
   input wire logic scan_clk,
   input wire logic [3:0] scan_chain_sel,
   input wire logic scan_capture,
   input wire logic scan_shift,
   input wire logic scan_update,
   input wire logic scan_tdi,
   output logic scan_tdo,
   output logic scan_busy,
   // Processor state and cache control.
   input wire logic debug_state,
   input wire logic cache_enable,
   output logic sysspeed_external,
   // Coprocessor register port.
   output logic cp_wr,
   output logic cp_rd,
   output logic cp_region,
   output logic [3:0] cp_num,
   output logic cp_iside,
   output logic [31:0] cp_wdata,
   input wire logic [31:0] cp_rdata,
   // Instruction cache flush.
   output logic instruction_cache_flush,
   input wire logic instruction_cache_flush_done,
   // Tag array port.
   output logic tag_rd,
   output logic tag_data_cache,
   output logic [6:0] tag_index,
   output logic [5:0] tag_segment,
   input wire logic tag_valid,
   input wire logic tag_dirty,
   input wire logic [26:0] tag_value
);
   import dsca_pkg::*;

   dsca_xfer_if xfer ();

   logic [CP_LEN-1:0] chain_reg;
   logic [CP_LEN-1:0] cmd_reg;
   logic [3:0] cmd_chain_reg;
   logic req_reg;
   logic ack_meta_reg;
   logic ack_sync_reg;
   logic sysspeed_ext_reg;
   logic pending;
   logic sel_cp;
   logic sel_tag;

   assign xfer.req_tgl = req_reg;
   assign xfer.cmd = cmd_reg;
   assign xfer.chain = cmd_chain_reg;
   assign sel_cp = (scan_chain_sel == CHAIN_CP);
   assign sel_tag = (scan_chain_sel == CHAIN_ITAG) || (scan_chain_sel == CHAIN_DTAG);
   assign pending = (req_reg != ack_sync_reg);
   assign scan_tdo = chain_reg[0];
   assign scan_busy = pending;

   // The answer toggle crosses back into the test clock through two flops.
   always_ff @(posedge scan_clk or posedge rst) begin
      if (rst) begin
         ack_meta_reg <= 1'b0;
         ack_sync_reg <= 1'b0;
      end else begin
         ack_meta_reg <= xfer.ack_tgl;
         ack_sync_reg <= ack_meta_reg;
      end
   end

   // Shift enters at the far end of the selected chain's length, out at bit 0.
   // Coprocessor results are only sampled once the answer toggle has returned, which
   // keeps the core-side word stable while it is read; tag captures do not wait.
   always_ff @(posedge scan_clk or posedge rst) begin
      if (rst) begin
         chain_reg <= CHAIN_RESET;
      end else if (scan_capture && sel_cp) begin
         chain_reg <= {cmd_reg[DIR_BIT:ADDR_LO],
            pending ? {1'b1, 31'h0000_0000} : xfer.result};
      end else if (scan_capture && sel_tag) begin
         chain_reg <= {10'h000, xfer.result[TAG_LEN-1:0]};
      end else if (scan_shift && sel_cp) begin
         chain_reg <= {scan_tdi, chain_reg[CP_LEN-1:1]};
      end else if (scan_shift && sel_tag) begin
         chain_reg <= {10'h000, scan_tdi, chain_reg[TAG_LEN-1:1]};
      end
   end

   // A new update is dropped while the previous one is still in flight.
   always_ff @(posedge scan_clk or posedge rst) begin
      if (rst) begin
         cmd_reg <= CHAIN_RESET;
         cmd_chain_reg <= 4'h0;
         req_reg <= 1'b0;
      end else if (scan_update && (sel_cp || sel_tag) && !pending) begin
         cmd_reg <= chain_reg;
         cmd_chain_reg <= scan_chain_sel;
         req_reg <= !req_reg;
      end
   end

   // With caching off, system-speed accesses bypass the cache entirely.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sysspeed_ext_reg <= 1'b1;
      end else begin
         sysspeed_ext_reg <= !cache_enable;
      end
   end
   assign sysspeed_external = sysspeed_ext_reg;

   dsca_core_engine u_engine (
      .sys_clk(sys_clk),
      .rst(rst),
      .xfer(xfer.core),
      .debug_state(debug_state),
      .cp_wr_reg(cp_wr),
      .cp_rd_reg(cp_rd),
      .cp_region_reg(cp_region),
      .cp_num_reg(cp_num),
      .cp_iside_reg(cp_iside),
      .cp_wdata_reg(cp_wdata),
      .cp_rdata(cp_rdata),
      .instruction_cache_flush_reg(instruction_cache_flush),
      .instruction_cache_flush_done(instruction_cache_flush_done),
      .tag_rd_reg(tag_rd),
      .tag_data_cache_reg(tag_data_cache),
      .tag_index_reg(tag_index),
      .tag_segment_reg(tag_segment),
      .tag_valid(tag_valid),
      .tag_dirty(tag_dirty),
      .tag_value(tag_value)
   );

   sequence cp_shift_step;
      scan_shift && sel_cp && !scan_capture;
   endsequence

   sequence fresh_update;
      scan_update && (sel_cp || sel_tag) && !pending;
   endsequence

   cp_shift_a: assert property (@(posedge scan_clk) disable iff (rst)
      cp_shift_step |=> chain_reg[CP_LEN-1] == $past(scan_tdi)
      && chain_reg[CP_LEN-2:0] == $past(chain_reg[CP_LEN-1:1]))
      else $error("coprocessor chain shift wrong");
   tag_shift_a: assert property (@(posedge scan_clk) disable iff (rst)
      scan_shift && sel_tag && !scan_capture |=> chain_reg[TAG_LEN-1] == $past(scan_tdi)
      && chain_reg[CP_LEN-1:TAG_LEN] == 10'h000) else $error("tag chain shift wrong");
   update_req_a: assert property (@(posedge scan_clk) disable iff (rst)
      fresh_update |=> req_reg != $past(req_reg) && cmd_reg == $past(chain_reg)
      ##1 pending) else $error("update not forwarded");
   busy_hold_a: assert property (@(posedge scan_clk) disable iff (rst)
      scan_update && pending |=> req_reg == $past(req_reg) && cmd_reg == $past(cmd_reg))
      else $error("update accepted while busy");
   cp_capture_a: assert property (@(posedge scan_clk) disable iff (rst)
      scan_capture && sel_cp && !pending |=> chain_reg[VAL_HI:0] == $past(xfer.result))
      else $error("coprocessor result not captured");
   tag_capture_a: assert property (@(posedge scan_clk) disable iff (rst)
      scan_capture && sel_tag && !pending |=> chain_reg[TAG_LEN-1:0] ==
      $past(xfer.result[TAG_LEN-1:0]) && chain_reg[CP_LEN-1:TAG_LEN] == 10'h000)
      else $error("tag reading format wrong");
   busy_status_a: assert property (@(posedge scan_clk) disable iff (rst)
      scan_capture && sel_cp && pending |=> chain_reg[FLUSH_STATUS_BIT] == 1'b1)
      else $error("busy capture must show bit 31 set");
endmodule : dsca_scan_top

/* dv/dsca_dbg_model.sv */
module dsca_dbg_model (
   // Test access port.
   output logic scan_clk,
   output logic [3:0] scan_chain_sel,
   output logic scan_capture,
   output logic scan_shift,
   output logic scan_update,
   output logic scan_tdi,
   // Device answers.
   input wire logic scan_tdo,
   input wire logic scan_busy
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [38:0] last_out = 39'h0;
   event got;
   initial begin
      scan_clk = 1'b0;
      scan_chain_sel = 4'h0;
      {scan_capture, scan_shift, scan_update, scan_tdi} = 4'h0;
   end
   // The test clock runs only while the debugger works the port.
   task automatic tick();
      #20 scan_clk = 1'b0;
      #40 scan_clk = 1'b1;
      #20;
   endtask : tick
   // An unused data line toggles, so a stale bit never passes for a good one.
   task automatic idle(input int n);
      repeat (n) begin
         scan_tdi = ~scan_tdi;
         tick();
      end
   endtask : idle
   task automatic xfer(input logic [3:0] sel, input int len, input logic [38:0] cmd);
      int i;
      last_out = 39'h0;
      scan_chain_sel = sel;
      scan_capture = 1'b1;
      tick();
      scan_capture = 1'b0;
      scan_shift = 1'b1;
      for (i = 0; i < len; i++) begin
         last_out[i] = scan_tdo;
         scan_tdi = cmd[i];
         tick();
      end
      scan_shift = 1'b0;
      scan_update = 1'b1;
      tick();
      scan_update = 1'b0;
      -> got;
      // A new update is sent only once the previous one has been answered or 150 idle ticks have passed.
      i = 0;
      while (scan_busy !== 1'b0 && i < 150) begin
         idle(1);
         i++;
      end
   endtask : xfer
endmodule : dsca_dbg_model

/* dv/dsca_scan_top_tb.sv */
module dsca_scan_top_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import dsca_pkg::*;
   localparam logic [39:0] NONE = 40'hFF_FFFF_FFFF;
   localparam logic [5:0] MAP [10] = '{6'h00, 6'h02, 6'h04, 6'h05, 6'h06, 6'h0A, 6'h0B,
      6'h12, 6'h13, 6'h1E};
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic debug_state = 1'b0;
   logic cache_enable = 1'b1;
   logic scan_clk, scan_capture, scan_shift, scan_update, scan_tdi, scan_tdo, scan_busy;
   logic [3:0] scan_chain_sel;
   logic sysspeed_external, cp_wr, cp_rd, cp_region, cp_iside, instruction_cache_flush, tag_rd, tag_data_cache;
   logic [3:0] cp_num;
   logic [31:0] cp_wdata;
   logic [31:0] cp_rdata = 32'h0;
   logic instruction_cache_flush_done = 1'b0;
   logic tag_valid = 1'b0;
   logic tag_dirty = 1'b0;
   logic [26:0] tag_value = 27'h0;
   logic [6:0] tag_index;
   logic [5:0] tag_segment;
   logic [31:0] cp_mem [64];
   logic [5:0] addr [12];
   logic [28:0] salt;
   logic [38:0] exp_q [$];
   logic [38:0] mask_q [$];
   logic [39:0] stb_q [$];
   logic [38:0] pend_v = 39'h0;
   logic [38:0] pend_m = 39'h0;
   logic [3:0] pend_sel = 4'h0;
   int flush_cnt = 0;
   int errors = 0;
   int samples_checked = 0;

   always #5 sys_clk = ~sys_clk;

   dsca_scan_top uut (
      .sys_clk, .rst, .scan_clk, .scan_chain_sel, .scan_capture, .scan_shift, .scan_update,
      .scan_tdi, .scan_tdo, .scan_busy, .debug_state, .cache_enable, .sysspeed_external,
      .cp_wr, .cp_rd, .cp_region, .cp_num, .cp_iside, .cp_wdata, .cp_rdata, .instruction_cache_flush,
      .instruction_cache_flush_done, .tag_rd, .tag_data_cache, .tag_index, .tag_segment, .tag_valid,
      .tag_dirty, .tag_value
   );

   dsca_dbg_model dbg (
      .scan_clk, .scan_chain_sel, .scan_capture, .scan_shift, .scan_update, .scan_tdi,
      .scan_tdo, .scan_busy
   );

   function automatic logic [28:0] tagf(input logic dc, input logic [6:0] i, input logic [5:0] s);
      return {i, s, dc, 15'h0} ^ salt;
   endfunction : tagf

   task automatic check(input string what, input logic [39:0] e, s, m);
      samples_checked++;
      if ((s & m) !== (e & m)) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, e & m, s & m);
      end
   endtask : check

   // Core side: register file, tag array and a flush that takes 800 core cycles.
   always @(posedge sys_clk) begin
      if (cp_wr === 1'b1) cp_mem[{cp_region, cp_num, cp_iside}] <= cp_wdata;
      cp_rdata <= cp_mem[{cp_region, cp_num, cp_iside}];
      {tag_valid, tag_dirty, tag_value} <= tagf(tag_data_cache, tag_index, tag_segment);
      flush_cnt <= instruction_cache_flush === 1'b1 ? 800 : (flush_cnt > 0 ? flush_cnt - 1 : 0);
      instruction_cache_flush_done <= flush_cnt == 1;
   end

   always @(posedge sys_clk) begin
      logic [39:0] seen;
      if ({cp_wr, cp_rd, instruction_cache_flush, tag_rd} !== 4'h0 && rst === 1'b0) begin
         seen = tag_rd ? {2'h3, 24'h0, tag_data_cache, tag_index, tag_segment}
            : instruction_cache_flush ? {2'h2, 38'h0}
            : {1'b0, cp_wr, cp_region, cp_num, cp_iside, cp_wr ? cp_wdata : 32'h0};
         check("strobe", stb_q.size() > 0 ? stb_q.pop_front() : NONE, seen, NONE);
      end
   end

   always @(dbg.got) begin
      logic [38:0] e, m;
      e = exp_q.pop_front();
      m = mask_q.pop_front();
      if (m !== 39'h0) check("readout", {1'b0, e}, {1'b0, dbg.last_out}, {1'b0, m});
   end

   // Each readout shows the answer to the command sent just before it; it is checked only when that command used the same chain.
   task automatic acc(input logic [3:0] sel, input logic [38:0] cmd, nv, nm,
         input logic [39:0] stb);
      exp_q.push_back(pend_v);
      mask_q.push_back(sel == pend_sel ? pend_m : 39'h0);
      if (stb !== NONE) stb_q.push_back(stb);
      dbg.xfer(sel, sel == CHAIN_CP ? CP_LEN : TAG_LEN, cmd);
      pend_v = nv;
      pend_m = nm;
      pend_sel = sel;
   endtask : acc

   task automatic cp(input logic wr, input logic [5:0] a, input logic [31:0] v,
         input logic hit, input logic [31:0] rv);
      acc(CHAIN_CP, {wr, a, v}, {wr, a, rv}, wr ? 39'h7F_0000_0000 : 39'h7F_FFFF_FFFF,
         hit ? {1'b0, wr, a, wr ? v : 32'h0} : NONE);
   endtask : cp

   task automatic tagrd(input logic dc);
      logic [6:0] idx;
      logic [5:0] seg;
      logic [28:0] e;
      idx = 7'($urandom_range(63));
      seg = 6'($urandom);
      e = tagf(dc, idx, seg);
      e[27] = e[27] & dc;
      acc(dc ? CHAIN_DTAG : CHAIN_ITAG, {10'h0, idx, 16'h0, seg}, {10'h0, e}, 39'h1FFF_FFFF,
         {2'h3, 24'h0, dc, idx, seg});
   endtask : tagrd

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : give_verdict

   initial begin
      #600us;
      errors++;
      give_verdict();
   end

   initial begin
      int i;
      logic [31:0] v;
      void'($urandom(59207));
      salt = 29'($urandom);
      for (i = 0; i < 64; i++) cp_mem[i] = $urandom;
      for (i = 0; i < 12; i++) addr[i] = i < 10 ? MAP[i] : {1'b1, 4'($urandom), i[0]};
      fork
         dbg.idle(2);
         repeat (20) @(posedge sys_clk);
      join
      rst <= 1'b0;
      debug_state <= 1'b1;
      cache_enable <= 1'b0;
      dbg.idle(2);
      for (i = 0; i < 12; i++) cp(1'b0, addr[i], 32'h0, 1'b1, cp_mem[addr[i]]);
      for (i = 0; i < 12; i++) begin
         v = $urandom;
         cp(1'b1, addr[i], v, 1'b1, 32'h0);
         cp(1'b0, addr[i], 32'h0, 1'b1, v);
      end
      cp(1'b1, 6'h08, $urandom, 1'b0, 32'h0);
      cp(1'b0, 6'h08, 32'h0, 1'b0, 32'h0);
      $display("test coprocessor_access done");
      acc(CHAIN_CP, {1'b1, FLUSH_ADDR, 32'h0}, 39'h0, 39'h0, {2'h2, 38'h0});
      acc(CHAIN_CP, {1'b0, FLUSH_ADDR, 32'h0}, {1'b0, FLUSH_ADDR, 32'h8000_0000},
         39'h7F_8000_0000, NONE);
      dbg.idle(120);
      acc(CHAIN_CP, {1'b0, FLUSH_ADDR, 32'h0}, {1'b0, FLUSH_ADDR, 32'h0}, 39'h7F_8000_0000,
         NONE);
      cp(1'b0, addr[0], 32'h0, 1'b1, cp_mem[addr[0]]);
      $display("test flush done");
      for (i = 0; i < 10; i++) tagrd(i > 4);
      $display("test tag_read done");
      @(posedge sys_clk) debug_state <= 1'b0;
      cp(1'b1, addr[0], 32'h5A5A_5A5A, 1'b0, 32'h0);
      cp(1'b0, addr[0], 32'h0, 1'b0, 32'h0);
      @(posedge sys_clk) debug_state <= 1'b1;
      cp(1'b0, addr[0], 32'h0, 1'b1, cp_mem[addr[0]]);
      cp(1'b0, addr[0], 32'h0, 1'b1, 32'h0);
      $display("test outside_debug done");
      for (i = 0; i < 2; i++) begin
         @(posedge sys_clk) cache_enable <= i[0] ^ 1'b1;
         repeat (3) @(posedge sys_clk);
         check("sysspeed", {39'h0, i[0]}, {39'h0, sysspeed_external}, 40'h1);
      end
      $display("test cache_switch done");
      repeat (20) @(posedge sys_clk);
      check("strobes left", 40'h0, 40'(stb_q.size()), NONE);
      give_verdict();
   end
endmodule : dsca_scan_top_tb
